// ### src/macx_pkg.sv
// Constants and types shared by the execution core and its ALU
package macx_pkg;
	// Working register addresses in data space
	localparam logic [7:0] WREG_BASE    = 8'h80;
	localparam logic [7:0] WREG_LAST    = 8'h83;
	// Opcode field positions
	localparam int         PTR_SEL_BIT  = 4;
	localparam int         DIR_BIT      = 4;
	localparam int         BIT_IDX_LSB  = 5;
	// Cycle counts per instruction class
	localparam logic [2:0] CYC_ALU      = 3'h4;
	localparam logic [2:0] CYC_REL      = 3'h2;
	localparam logic [2:0] CYC_CTRL     = 3'h2;
	localparam logic [2:0] CYC_BTST     = 3'h5;
	localparam logic [2:0] CYC_ZERO     = 3'h0;
	// Flag, accumulator and program counter reset values
	localparam logic       FLAG_RST     = 1'b0;
	localparam logic [7:0] ACC_RST      = 8'h00;
	localparam logic [11:0] PC_RST      = 12'h000;

	// Decoded operation
	typedef enum logic [4:0] {
		MACX_OP_NOP, MACX_OP_ADD, MACX_OP_AND, MACX_OP_CMP, MACX_OP_SUB,
		MACX_OP_CLEAR, MACX_OP_DECR, MACX_OP_INC, MACX_OP_INVERT,
		MACX_OP_ROTL, MACX_OP_SHL, MACX_OP_BRC, MACX_OP_BRNC, MACX_OP_BRZ,
		MACX_OP_BRNZ, MACX_OP_BTCLR, MACX_OP_BTSET, MACX_OP_BSET,
		MACX_OP_BCLR, MACX_OP_JUMP, MACX_OP_CALL, MACX_OP_RET, MACX_OP_IRET,
		MACX_OP_STOP, MACX_OP_WAIT
	} macx_op_t;

	// Operand source
	typedef enum logic [2:0] {
		MACX_SRC_IMM, MACX_SRC_DIR, MACX_SRC_IND, MACX_SRC_SHORT,
		MACX_SRC_ACC
	} macx_src_t;

	// Execution state machine, one-hot
	typedef enum logic [2:0] {
		MACX_ST_IDLE = 3'b001,
		MACX_ST_EXEC = 3'b010,
		MACX_ST_HALT = 3'b100
	} macx_state_t;

	// Bit mask from a 3-bit index
	function automatic logic [7:0] macx_bit_mask(input logic [2:0] idx);
		macx_bit_mask = 8'h01 << idx;
	endfunction
endpackage

// ### src/macx_alu.sv
// Accumulator ALU with zero and carry results
`timescale 1ns/1ps
`default_nettype none
module macx_alu
	import macx_pkg::*;
(
	input  wire logic [4:0] op,
	input  wire logic [7:0] acc,
	input  wire logic [7:0] opnd,
	input  wire logic       cin,
	output logic [7:0]      res,
	output logic            zout,
	output logic            cout,
	output logic            cwr
);
	logic [8:0] sum;
	logic [8:0] dif;

	// Arithmetic terms
	assign sum = {1'b0, acc} + {1'b0, opnd};
	assign dif = {1'b0, acc} - {1'b0, opnd};

	// Operation selection
	always_comb begin
		res  = acc;
		cout = cin;
		cwr  = 1'b1;
		case (macx_op_t'(op))
			MACX_OP_ADD: begin
				res  = sum[7:0];
				cout = sum[8];
			end
			MACX_OP_AND: res = acc & opnd;
			MACX_OP_CMP: cout = dif[8];
			MACX_OP_SUB: begin
				res  = dif[7:0];
				cout = dif[8];
			end
			MACX_OP_CLEAR: begin
				res  = 8'h00;
				cout = 1'b0;
			end
			MACX_OP_DECR: begin
				res = opnd - 8'h01;
				cwr = 1'b0;
			end
			MACX_OP_INC: begin
				res = opnd + 8'h01;
				cwr = 1'b0;
			end
			MACX_OP_INVERT: begin
				res  = ~acc;
				cout = acc[7];
			end
			MACX_OP_ROTL: begin
				res  = {acc[6:0], cin};
				cout = acc[7];
			end
			MACX_OP_SHL: begin
				res  = {acc[6:0], 1'b0};
				cout = acc[7];
			end
			default: cwr = 1'b0;
		endcase
	end

	// Zero from the compare difference or the result
	assign zout = (macx_op_t'(op) == MACX_OP_CMP) ? (dif[7:0] == 8'h00)
		: (res == 8'h00);
endmodule
`default_nettype wire

// ### src/macx_core.sv
// Execution core for ALU, branch, bit and control instructions
`timescale 1ns/1ps
`default_nettype none
module macx_core
	import macx_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        instr_valid,
	input  wire logic [4:0]  instr_op,
	input  wire logic [2:0]  instr_src,
	input  wire logic [7:0]  instr_opcode,
	input  wire logic [7:0]  instr_arg1,
	input  wire logic [7:0]  instr_arg2,
	input  wire logic [11:0] instr_pc,
	input  wire logic        watchdog_opt,
	input  wire logic        wake,
	input  wire logic [1:0]  saved_flags,
	input  wire logic [11:0] ret_addr,
	input  wire logic [7:0]  mem_rdata,
	output logic             instr_ready,
	output logic [7:0]       mem_addr,
	output logic             mem_we,
	output logic [7:0]       mem_wdata,
	output logic [7:0]       acc_ff,
	output logic             zero_ff,
	output logic             carry_ff,
	output logic [11:0]      pc_ff,
	output logic             stop_ff,
	output logic             wait_ff,
	output logic             push_ff,
	output logic             done_ff
);
	macx_state_t state_ff, nxt_state;
	logic [2:0]  cnt_ff, nxt_cnt;
	logic [2:0]  rs_ff;
	logic [2:0]  wdog_ff;
	logic        wdog_sel;
	logic [4:0]  op_ff;
	logic [2:0]  src_ff;
	logic [7:0]  opc_ff, a1_ff, a2_ff;
	logic [11:0] ipc_ff;
	logic        rst_q;
	logic [7:0]  x_ff, y_ff, v_ff, w_ff;
	macx_op_t    opk;
	macx_src_t   srck;
	logic [7:0]  opnd_addr, opnd_val, bit_mask, alu_res;
	logic        alu_z, alu_c, alu_cwr, bit_val, cond, fin;
	logic [11:0] rel_tgt, btst_tgt, tgt;
	logic [2:0]  cyc_need;
	logic        is_wr_mem, is_bit, is_btst, is_rel, is_alu_acc;

	////////////////////////////////////////////////////////////////////
	// Reset release and watchdog option synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rs_ff   <= 3'h0;
			wdog_ff <= 3'h0;
		end else begin
			rs_ff   <= {rs_ff[1:0], 1'b1};
			wdog_ff <= {wdog_ff[1:0], watchdog_opt};
		end
	end
	assign rst_q = rs_ff[1];

	// Watchdog option counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wdog_sel <= 1'b0;
		else if (wdog_ff[1] == wdog_ff[2])
			wdog_sel <= wdog_ff[2];
	end

	////////////////////////////////////////////////////////////////////
	// Decode
	assign opk  = macx_op_t'(op_ff);
	assign srck = macx_src_t'(src_ff);
	assign bit_mask = macx_bit_mask(opc_ff[BIT_IDX_LSB +: 3]);
	assign bit_val  = |(mem_rdata & bit_mask);
	assign is_bit   = (opk == MACX_OP_BSET) || (opk == MACX_OP_BCLR);
	assign is_btst  = (opk == MACX_OP_BTCLR) || (opk == MACX_OP_BTSET);
	assign is_rel   = (opk >= MACX_OP_BRC) && (opk <= MACX_OP_BRNZ);
	assign is_alu_acc = (opk >= MACX_OP_ADD) && (opk <= MACX_OP_SUB)
		|| (opk >= MACX_OP_INVERT) && (opk <= MACX_OP_SHL);
	assign is_wr_mem = ((opk == MACX_OP_CLEAR) || (opk == MACX_OP_DECR)
		|| (opk == MACX_OP_INC)) && (srck != MACX_SRC_ACC);

	// Operand address: direct, indirect via pointer, short direct
	assign opnd_addr = (srck == MACX_SRC_IND) ?
		(opc_ff[PTR_SEL_BIT] ? y_ff : x_ff) :
		(srck == MACX_SRC_SHORT) ? (WREG_BASE | {6'h00, opc_ff[1:0]}) :
		a1_ff;

	// Operand value: immediate, accumulator-only or memory
	assign opnd_val = (srck == MACX_SRC_IMM) ? a1_ff :
		(srck == MACX_SRC_ACC) ? acc_ff : mem_rdata;

	macx_alu u_alu (
		.op   (op_ff),
		.acc  ((is_wr_mem || opk == MACX_OP_DECR || opk == MACX_OP_INC)
			? opnd_val : acc_ff),
		.opnd (opnd_val),
		.cin  (carry_ff),
		.res  (alu_res),
		.zout (alu_z),
		.cout (alu_c),
		.cwr  (alu_cwr)
	);

	// Branch condition
	assign cond = (opk == MACX_OP_BRC)   ?  carry_ff :
		(opk == MACX_OP_BRNC)  ? ~carry_ff :
		(opk == MACX_OP_BRZ)   ?  zero_ff  :
		(opk == MACX_OP_BRNZ)  ? ~zero_ff  :
		(opk == MACX_OP_BTCLR) ? ~bit_val  :
		(opk == MACX_OP_BTSET) ?  bit_val  : 1'b0;

	// Targets: 4-bit span with direction bit, 8-bit signed, 12-bit
	assign rel_tgt = opc_ff[DIR_BIT] ?
		ipc_ff - {8'h00, opc_ff[3:0]} :
		ipc_ff + {8'h00, opc_ff[3:0]} + 12'h001;
	assign btst_tgt = ipc_ff + 12'h002
		+ {{4{a2_ff[7]}}, a2_ff};
	assign tgt = is_rel ? rel_tgt : is_btst ? btst_tgt :
		{opc_ff[3:0], a1_ff};

	// Cycle budget per class
	assign cyc_need = is_btst ? CYC_BTST :
		is_rel ? CYC_REL :
		(opk >= MACX_OP_RET) ? CYC_CTRL :
		(opk == MACX_OP_NOP) ? CYC_CTRL : CYC_ALU;
	assign fin = (state_ff == MACX_ST_EXEC) && (cnt_ff == cyc_need - 3'h1);

	////////////////////////////////////////////////////////////////////
	// State machine
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			MACX_ST_IDLE: begin
				nxt_cnt = CYC_ZERO;
				if (instr_valid && rst_q)
					nxt_state = MACX_ST_EXEC;
			end
			MACX_ST_EXEC: begin
				nxt_cnt = cnt_ff + 3'h1;
				if (fin)
					nxt_state = (opk == MACX_OP_STOP || opk == MACX_OP_WAIT)
						? MACX_ST_HALT : MACX_ST_IDLE;
			end
			MACX_ST_HALT: begin
				if (wake)
					nxt_state = MACX_ST_IDLE;
			end
			default: nxt_state = MACX_ST_IDLE;
		endcase
	end
	assign instr_ready = (state_ff == MACX_ST_IDLE) && rst_q;

	// Data memory port, written on the last cycle
	assign mem_addr  = opnd_addr;
	assign mem_we    = fin && (is_wr_mem || is_bit);
	assign mem_wdata = (opk == MACX_OP_BSET) ? (mem_rdata | bit_mask) :
		(opk == MACX_OP_BCLR) ? (mem_rdata & ~bit_mask) :
		alu_res;

	////////////////////////////////////////////////////////////////////
	// Sequencer and latched instruction
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= MACX_ST_IDLE;
			cnt_ff   <= CYC_ZERO;
			op_ff    <= 5'h00;
			src_ff   <= 3'h0;
			opc_ff   <= 8'h00;
			a1_ff    <= 8'h00;
			a2_ff    <= 8'h00;
			ipc_ff   <= PC_RST;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			if (instr_ready && instr_valid) begin
				op_ff  <= instr_op;
				src_ff <= instr_src;
				opc_ff <= instr_opcode;
				a1_ff  <= instr_arg1;
				a2_ff  <= instr_arg2;
				ipc_ff <= instr_pc;
			end
		end
	end

	// Shadow copies of the working registers for pointer use
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			x_ff <= 8'h00;
			y_ff <= 8'h00;
			v_ff <= 8'h00;
			w_ff <= 8'h00;
		end else if (mem_we && mem_addr >= WREG_BASE
			&& mem_addr <= WREG_LAST) begin
			case (mem_addr[1:0])
				2'h0: x_ff <= mem_wdata;
				2'h1: y_ff <= mem_wdata;
				2'h2: v_ff <= mem_wdata;
				default: w_ff <= mem_wdata;
			endcase
		end
	end

	// Accumulator, flags, program counter and control results
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff   <= ACC_RST;
			zero_ff  <= FLAG_RST;
			carry_ff <= FLAG_RST;
			pc_ff    <= PC_RST;
			stop_ff  <= 1'b0;
			wait_ff  <= 1'b0;
			push_ff  <= 1'b0;
			done_ff  <= 1'b0;
		end else begin
			done_ff <= fin;
			push_ff <= fin && (opk == MACX_OP_CALL);
			if (state_ff == MACX_ST_HALT && wake) begin
				stop_ff <= 1'b0;
				wait_ff <= 1'b0;
			end
			if (fin) begin
				// Untaken bit test skips its three bytes
				pc_ff <= is_btst ? ipc_ff + 12'h003 : ipc_ff + 12'h001;
				if (is_alu_acc && opk != MACX_OP_CMP)
					acc_ff <= alu_res;
				if (is_alu_acc || is_wr_mem
					|| (opk == MACX_OP_CLEAR) || (opk == MACX_OP_DECR)
					|| (opk == MACX_OP_INC)) begin
					zero_ff <= alu_z;
					if (alu_cwr)
						carry_ff <= alu_c;
				end
				if ((opk == MACX_OP_DECR || opk == MACX_OP_INC
					|| opk == MACX_OP_CLEAR) && srck == MACX_SRC_ACC)
					acc_ff <= alu_res;
				if (is_btst || is_bit)
					carry_ff <= bit_val;
				if (cond || opk == MACX_OP_JUMP || opk == MACX_OP_CALL)
					pc_ff <= tgt;
				if (opk == MACX_OP_RET || opk == MACX_OP_IRET)
					pc_ff <= ret_addr;
				if (opk == MACX_OP_IRET)
					{zero_ff, carry_ff} <= saved_flags;
				if (opk == MACX_OP_STOP && !wdog_sel)
					stop_ff <= 1'b1;
				if (opk == MACX_OP_WAIT
					|| (opk == MACX_OP_STOP && wdog_sel))
					wait_ff <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/macx_core_sva.sv
// Checker for the execution core ports
`timescale 1ns/1ps
`default_nettype none
module macx_core_sva
	import macx_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       instr_valid,
	input wire logic [4:0] instr_op,
	input wire logic       watchdog_opt,
	input wire logic       instr_ready,
	input wire logic       mem_we,
	input wire logic       zero_ff,
	input wire logic       carry_ff,
	input wire logic       stop_ff,
	input wire logic       wait_ff,
	input wire logic       done_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////
	// Taken instruction and its class
	wire tk = instr_valid && instr_ready;
	wire c4 = instr_op inside {[MACX_OP_ADD:MACX_OP_SHL], MACX_OP_BSET,
		MACX_OP_BCLR};
	wire c2 = instr_op inside {[MACX_OP_BRC:MACX_OP_BRNZ], MACX_OP_NOP,
		MACX_OP_RET, MACX_OP_IRET};
	wire c5 = instr_op inside {MACX_OP_BTCLR, MACX_OP_BTSET};
	wire bo = instr_op inside {MACX_OP_BSET, MACX_OP_BCLR};
	wire ao = instr_op inside {[MACX_OP_INVERT:MACX_OP_SHL]};
	logic [3:0] wd_ff;
	logic [3:0] nxt_wd;
	// Length of the current high option level, saturating
	assign nxt_wd = !watchdog_opt ? 4'h0 : wd_ff + {3'h0, wd_ff != 4'hf};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) wd_ff <= 4'h0;
		else wd_ff <= nxt_wd;
	end
	////////////////////////////////
	property p_cyc4;
		tk && c4 |=> !done_ff [*4] ##1 done_ff;
	endproperty
	a_cyc4: assert property (p_cyc4)
		else $error("four-cycle op timing");
	property p_cyc2;
		tk && c2 |=> !done_ff [*2] ##1 done_ff;
	endproperty
	a_cyc2: assert property (p_cyc2)
		else $error("two-cycle op timing");
	property p_cyc5;
		tk && c5 |=> !done_ff [*5] ##1 done_ff;
	endproperty
	a_cyc5: assert property (p_cyc5)
		else $error("bit test timing");
	property p_btzero;
		tk && (c5 || bo) |=> $stable(zero_ff) [*5];
	endproperty
	a_btzero: assert property (p_btzero)
		else $error("zero flag moved by bit op");
	property p_bitwe;
		tk && bo |=> !mem_we [*3] ##1 mem_we ##1 !mem_we;
	endproperty
	a_bitwe: assert property (p_bitwe)
		else $error("bit op write-back");
	property p_acconly;
		tk && ao |=> !mem_we [*5];
	endproperty
	a_acconly: assert property (p_acconly)
		else $error("accumulator op wrote memory");
	property p_halt;
		stop_ff || wait_ff |-> !instr_ready;
	endproperty
	a_halt: assert property (p_halt)
		else $error("ready while halted");
	property p_wdog;
		wd_ff >= 4'h8 |-> !$rose(stop_ff);
	endproperty
	a_wdog: assert property (p_wdog)
		else $error("stop under watchdog option");
	c_btst: cover property (tk && c5);
	c_wait: cover property ($rose(wait_ff));
	c_stop: cover property ($rose(stop_ff));
endmodule
`default_nettype wire

// ### sim/mcu_alu_branch_control_exec_test.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	bad_count++; $display("CHECK FAILED t=%0t got %h exp %h", \
	$time, g, e); end end
module mcu_alu_branch_control_exec_test
	import macx_pkg::*;
;
	logic        clk, rst_n, instr_valid, watchdog_opt, wake, mz, mc;
	logic        instr_ready, mem_we, zero_ff, carry_ff, cnd;
	logic        stop_ff, wait_ff, done_ff, push_ff;
	logic [1:0]  saved_flags;
	logic [2:0]  instr_src;
	logic [4:0]  instr_op;
	logic [4:0]  bro [4];
	logic [7:0]  instr_opcode, instr_arg1, instr_arg2, mem_rdata;
	logic [7:0]  mem_addr, mem_wdata, acc_ff, ma, b, d, v;
	logic [7:0]  mem [256];
	logic [8:0]  t;
	logic [11:0] instr_pc, ret_addr, pc_ff, xp;
	int          bad_count, check_count, seed, k;
	////////////////////////////////
	// Device under test and its data space
	macx_core macx_core_i (
		.clk, .rst_n, .instr_valid, .instr_op, .instr_src, .instr_opcode,
		.instr_arg1, .instr_arg2, .instr_pc, .watchdog_opt, .wake,
		.saved_flags, .ret_addr, .mem_rdata, .instr_ready, .mem_addr,
		.mem_we, .mem_wdata, .acc_ff, .zero_ff, .carry_ff, .pc_ff,
		.stop_ff, .wait_ff, .push_ff, .done_ff
	);
	assign mem_rdata = mem[mem_addr];
	always @(posedge clk) if (mem_we) mem[mem_addr] <= mem_wdata;
	always #2 clk = ~clk;
	////////////////////////////////
	// Offers one instruction, counts edges until done
	task automatic ex(input logic [4:0] o, input logic [2:0] s,
		input logic [7:0] oc, input logic [7:0] x, input int n);
		int j;
		j = 0;
		while (instr_ready !== 1'b1 && j < 40) begin
			@(posedge clk) #1;
			j++;
		end
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_op <= o;
		instr_src <= s;
		instr_opcode <= oc;
		instr_arg1 <= x;
		instr_arg2 <= 8'($random(seed));
		instr_pc <= 12'($random(seed));
		saved_flags <= 2'($random(seed));
		ret_addr <= 12'($random(seed));
		@(posedge clk);
		instr_valid <= 1'b0;
		j = 0;
		while (n > 0 && done_ff !== 1'b1 && j < 20) begin
			@(posedge clk) #1;
			j++;
		end
		if (n > 0) `CHK(j, n)
	endtask
	// Expected address after a flag branch
	function automatic logic [11:0] rel_pc(input logic [11:0] p,
		input logic [4:0] e, input logic go);
		if (!go) return p + 12'h1;
		return e[4] ? p - {8'h0, e[3:0]} : p + {8'h0, e[3:0]} + 12'h1;
	endfunction
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	////////////////////////////////
	initial begin
		{clk, rst_n, instr_valid, watchdog_opt, wake, instr_op} = '0;
		{instr_src, instr_opcode, instr_arg1, instr_arg2} = '0;
		{instr_pc, saved_flags, ret_addr, ma, mz, mc} = '0;
		{bad_count, check_count, seed} = {32'h0, 32'h0, 32'hab6f};
		bro = '{MACX_OP_BRC, MACX_OP_BRNC, MACX_OP_BRZ, MACX_OP_BRNZ};
		for (int i = 0; i < 256; i++) mem[i] = 8'($random(seed));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// Short direct increments, which also set the pointers
		for (int r = 0; r < 4; r++) begin
			v = mem[{6'h20, 2'(r)}];
			ex(MACX_OP_INC, MACX_SRC_SHORT, {6'h0, 2'(r)}, 8'h0, 4);
			mz = v == 8'hff;
			`CHK(mem[{6'h20, 2'(r)}], v + 8'h1)
			`CHK({zero_ff, carry_ff}, {mz, mc})
		end
		// Clear and decrement at random direct addresses
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			v = mem[d];
			ex(i[0] ? MACX_OP_CLEAR : MACX_OP_DECR, MACX_SRC_DIR, 8'h0, d, 4);
			{mz, mc} = i[0] ? 2'b10 : {v == 8'h01, mc};
			`CHK(mem[d], i[0] ? 8'h00 : v - 8'h1)
			`CHK({zero_ff, carry_ff}, {mz, mc})
		end
		// Add immediate, then a flag branch, spans at both limits
		for (int i = 0; i < 16; i++) begin
			b = i[2] ? -ma : 8'($random(seed));
			t = {1'b0, ma} + {1'b0, b};
			ex(MACX_OP_ADD, MACX_SRC_IMM, 8'h0, b, 4);
			{mc, ma} = t;
			mz = ma == 8'h00;
			`CHK({acc_ff, zero_ff, carry_ff}, {ma, mz, mc})
			v = 8'($random(seed));
			if (i < 8) v[4:0] = i[2] ? 5'h1f : 5'h0f;
			cnd = (i[1] ? mz : mc) ^ i[0];
			ex(bro[i[1:0]], MACX_SRC_ACC, v, 8'h0, 2);
			`CHK(pc_ff, rel_pc(instr_pc, v[4:0], cnd))
			`CHK({zero_ff, carry_ff}, {mz, mc})
		end
		// Subtract direct, compare through either pointer
		for (int i = 0; i < 8; i++) begin
			d = i[0] ? 8'($random(seed)) : mem[{7'h40, i[1]}];
			t = {1'b0, ma} - {1'b0, mem[d]};
			ex(i[0] ? MACX_OP_SUB : MACX_OP_CMP, i[0] ? MACX_SRC_DIR :
				MACX_SRC_IND, {3'h0, i[1], 4'h0}, d, 4);
			ma = i[0] ? t[7:0] : ma;
			{mz, mc} = {t[7:0] == 8'h00, t[8]};
			`CHK({acc_ff, zero_ff, carry_ff}, {ma, mz, mc})
		end
		// Accumulator-only operations
		ex(MACX_OP_INVERT, MACX_SRC_ACC, 8'h0, 8'h0, 4);
		ma = ~ma;
		`CHK({acc_ff, zero_ff}, {ma, ma == 8'h00})
		ex(MACX_OP_SHL, MACX_SRC_ACC, 8'h0, 8'h0, 4);
		{mc, ma} = {ma, 1'b0};
		`CHK({acc_ff, carry_ff}, {ma, mc})
		ex(MACX_OP_ROTL, MACX_SRC_ACC, 8'h0, 8'h0, 4);
		{mc, ma} = {ma, mc};
		mz = ma == 8'h00;
		`CHK({acc_ff, zero_ff, carry_ff}, {ma, mz, mc})
		// Bit set or clear, then bit-test branch, on each index
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			v = mem[d];
			ex(i[0] ? MACX_OP_BSET : MACX_OP_BCLR, MACX_SRC_DIR,
				{3'(i), 5'h0}, d, 4);
			mc = v[i];
			`CHK(mem[d], i[0] ? v | (8'h01 << i) : v & ~(8'h01 << i))
			`CHK({zero_ff, carry_ff}, {mz, mc})
			d = 8'($random(seed));
			mc = mem[d][i];
			cnd = mc ^ i[1];
			ex(i[1] ? MACX_OP_BTCLR : MACX_OP_BTSET, MACX_SRC_DIR,
				{3'(i), 5'h0}, d, 5);
			xp = instr_pc + 12'h3;
			if (cnd) xp = instr_pc + 12'h2 + {{4{instr_arg2[7]}}, instr_arg2};
			`CHK(pc_ff, xp)
			`CHK({zero_ff, carry_ff}, {mz, mc})
		end
		// No-op, returns and long jump
		ex(MACX_OP_NOP, MACX_SRC_ACC, 8'h0, 8'h0, 2);
		`CHK({zero_ff, carry_ff}, {mz, mc})
		ex(MACX_OP_RET, MACX_SRC_ACC, 8'h0, 8'h0, 2);
		`CHK({zero_ff, carry_ff, pc_ff}, {mz, mc, ret_addr})
		ex(MACX_OP_IRET, MACX_SRC_ACC, 8'h0, 8'h0, 2);
		`CHK({zero_ff, carry_ff, pc_ff}, {saved_flags, ret_addr})
		{v, b} = 16'($random(seed));
		ex(MACX_OP_JUMP, MACX_SRC_IMM, v, b, 4);
		`CHK({pc_ff, push_ff}, {v[3:0], b, 1'b0})
		{v, b} = 16'($random(seed));
		ex(MACX_OP_CALL, MACX_SRC_IMM, v, b, 4);
		`CHK({pc_ff, push_ff}, {v[3:0], b, 1'b1})
		// Stop, stop with the watchdog option, wait; each then woken
		for (int j = 0; j < 3; j++) begin
			@(posedge clk);
			watchdog_opt <= j == 1;
			repeat (8) @(posedge clk);
			ex(j == 2 ? MACX_OP_WAIT : MACX_OP_STOP, MACX_SRC_ACC, 8'h0,
				8'h0, 0);
			k = 0;
			while ((stop_ff | wait_ff) !== 1'b1 && k < 20) begin
				@(posedge clk) #1;
				k++;
			end
			`CHK({stop_ff, wait_ff}, j == 0 ? 2'b10 : 2'b01)
			@(posedge clk);
			wake <= 1'b1;
			k = 0;
			while (instr_ready !== 1'b1 && k < 40) begin
				@(posedge clk) #1;
				k++;
			end
			`CHK({stop_ff, wait_ff}, 2'b00)
			@(posedge clk);
			wake <= 1'b0;
		end
		end_sim();
	end
	// Cuts a hung run short
	initial begin
		#20000;
		bad_count++;
		end_sim();
	end
endmodule
bind macx_core macx_core_sva macx_core_sva_i (
	.clk, .rst_n, .instr_valid, .instr_op, .watchdog_opt, .instr_ready,
	.mem_we, .zero_ff, .carry_ff, .stop_ff, .wait_ff, .done_ff
);
`default_nettype wire
